//--- include/lcd_driver_pkg.sv
package lcd_driver_pkg;

    // drive level codes, two bits per output
    localparam logic [1:0] LVL_HIGH_RAIL  = 2'h0;
    localparam logic [1:0] LVL_BIAS_UPPER = 2'h1;
    localparam logic [1:0] LVL_BIAS_LOWER = 2'h2;
    localparam logic [1:0] LVL_LOW_RAIL   = 2'h3;

    // geometry
    localparam int NUM_DOTS_DEF = 80;
    localparam int LATCH_WORDS  = 3;
    localparam int LATCH_BITS   = 32 * LATCH_WORDS;

    // register byte offsets
    localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFS_LATCH0 = 32'h0000_0008;
    localparam logic [31:0] OFS_LATCH1 = 32'h0000_000c;
    localparam logic [31:0] OFS_LATCH2 = 32'h0000_0010;

    // control fields
    localparam int CTRL_SHIFT_EN_BIT   = 0;
    localparam int CTRL_CLR_FAST_BIT   = 1;
    localparam logic CTRL_SHIFT_EN_RST = 1'b1;

    // status fields
    localparam int STAT_CASCADE_BIT = 0;
    localparam int STAT_LOAD_BIT    = 1;
    localparam int STAT_ROLE_BIT    = 2;
    localparam int STAT_ALT_BIT     = 3;
    localparam int STAT_FAST_BIT    = 4;
    localparam int STAT_COUNT_LSB   = 16;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // timing: fastest legal shift clock against the system clock
    localparam int CLK_FREQ_KHZ       = 20000;
    localparam int SHIFT_MAX_FREQ_KHZ = 3300;
    localparam int SHIFT_MIN_PERIOD_CYC =
        (CLK_FREQ_KHZ + SHIFT_MAX_FREQ_KHZ - 1) / SHIFT_MAX_FREQ_KHZ;
    localparam logic [3:0] GAP_MIN = 4'(SHIFT_MIN_PERIOD_CYC);

endpackage

//--- testbench/lcd_controller_model.sv
`timescale 1ns/10ps
`default_nettype none

module lcd_controller_model
(
    // clock
    input  wire logic clk,
    // controller pins
    output logic      serial_display_in,
    output logic      shift_clock_pin,
    output logic      load_strobe,
    output logic      frame_alternation
);

    // idle: shift clock stands high, data line carries no meaning
    initial
    begin
        serial_display_in = 1'b0;
        shift_clock_pin   = 1'b1;
        load_strobe       = 1'b1;
        frame_alternation = 1'b0;
    end

    // latch strobe and drive polarity, changed just after an edge
    task automatic set_mode(input logic ld, input logic alt);
        load_strobe       <= ld;
        frame_alternation <= alt;
    endtask

    // one bit: data settles while high, clock falls, data held past rise
    // period is 7 + slow cycles; a negative slow breaks the ceiling on purpose
    task automatic send_bit(input logic b, input int slow);
        repeat (2 + slow) @(posedge clk);
        serial_display_in <= b;
        repeat (2) @(posedge clk);
        shift_clock_pin <= 1'b0;
        repeat (2) @(posedge clk);
        shift_clock_pin <= 1'b1;
        @(posedge clk);
        serial_display_in <= ~b; // hold over, line no longer valid
    endtask

endmodule // lcd_controller_model

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module testbench;
    import lcd_driver_pkg::*;
    localparam int N = 80;

    logic              clk, reset, role_select, cascade_out;
    logic              serial_display_in, shift_clock_pin;
    logic              load_strobe, frame_alternation;
    logic [2*N-1:0]    drive_outputs;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic [31:0]       d;
    logic [N-1:0]      p, q;
    logic [2*N-1:0]    drive_next;
    logic              cascade_next;
    int                miscompares, checked;

    lcd_row_column_driver #(.NUM_DOTS(N)) DUT (
        .clk, .reset, .serial_display_in, .shift_clock_pin,
        .load_strobe, .frame_alternation, .role_select, .cascade_out,
        .drive_outputs, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp
    );

    lcd_controller_model ctrl (
        .clk, .serial_display_in, .shift_clock_pin,
        .load_strobe, .frame_alternation
    );

    // second device chained behind the first on the shared shift clock
    lcd_row_column_driver #(.NUM_DOTS(N)) DUT_next (
        .clk, .reset,
        .serial_display_in (cascade_out),
        .shift_clock_pin, .load_strobe, .frame_alternation, .role_select,
        .cascade_out       (cascade_next),
        .drive_outputs     (drive_next),
        .s_axi_awvalid     (1'b0),
        .s_axi_awready     (),
        .s_axi_awaddr      (32'h0000_0000),
        .s_axi_wvalid      (1'b0),
        .s_axi_wready      (),
        .s_axi_wdata       (32'h0000_0000),
        .s_axi_wstrb       (4'h0),
        .s_axi_bvalid      (),
        .s_axi_bready      (1'b0),
        .s_axi_bresp       (),
        .s_axi_arvalid     (1'b0),
        .s_axi_arready     (),
        .s_axi_araddr      (32'h0000_0000),
        .s_axi_rvalid      (),
        .s_axi_rready      (1'b0),
        .s_axi_rdata       (),
        .s_axi_rresp       ()
    );

    // free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // expected code of one output from its dot, polarity and role
    function automatic logic [1:0] lvl(logic b, logic alt, logic role);
        if (b)
            return (role == alt) ? LVL_HIGH_RAIL : LVL_LOW_RAIL;
        return alt ? LVL_BIAS_LOWER : LVL_BIAS_UPPER;
    endfunction

    // expected outputs, output k+1 in bits 2k+1..2k
    function automatic logic [2*N-1:0] drv(logic [N-1:0] v, logic a,
                                           logic role);
        logic [2*N-1:0] o;
        for (int k = 0; k < N; k++)
            o[2*k +: 2] = lvl(v[k], a, role);
        return o;
    endfunction

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // last bit sent lands at position 1, so send the top bit first
    task automatic fill(input logic [N-1:0] v, input int slow);
        for (int i = N - 1; i >= 0; i--)
            ctrl.send_bit(v[i], slow);
        repeat (4) @(posedge clk);
    endtask

    // ready sampled mid-cycle, so the taking edge is known without a race
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
        logic ta, tw;
        int   n;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge clk);
            if (s_axi_bvalid)
                break;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        r = s_axi_bresp;
        if (n == 40) begin miscompares++; conclude(); end
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        logic t;
        int   n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge clk);
            if (s_axi_rvalid)
                break;
            t = s_axi_arvalid && s_axi_arready;
            @(posedge clk);
            if (t) s_axi_arvalid <= 1'b0;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 40) begin miscompares++; conclude(); end
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        miscompares = 0;
        checked = 0;
        reset = 1'b1;
        role_select = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'h0000_03ca));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // every role and polarity, load tied high as a common driver would
        for (int m = 0; m < 4; m++)
        begin
            role_select <= m[1];
            ctrl.set_mode(1'b1, m[0]);
            p = N'({$urandom, $urandom, $urandom});
            if (m == 1) p = {N{1'b1}};
            if (m == 2) p = {{N-1{1'b0}}, 1'b1};
            fill(p, m % 3);
            `CHK("drive", drv(p, m[0], m[1]), drive_outputs)
            `CHK("cascade", p[N-1], cascade_out)
            axi_rd(OFS_LATCH0);
            `CHK("latch0", p[31:0], d)
        end
        // strobe low: outputs keep the old dots, polarity still applies
        ctrl.set_mode(1'b0, 1'b0);
        q = ~p;
        fill(q, 0);
        `CHK("hold", drv(p, 1'b0, 1'b1), drive_outputs)
        ctrl.set_mode(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        `CHK("hold_alt", drv(p, 1'b1, 1'b1), drive_outputs)
        ctrl.set_mode(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        `CHK("release", drv(q, 1'b1, 1'b1), drive_outputs)
        `CHK("chain", drv(p, 1'b1, 1'b1), drive_next)
        `CHK("chain_casc", p[N-1], cascade_next)
        // shifting switched off through the control register
        axi_wr(OFS_CTRL, 32'h0000_0000);
        `CHK("bresp", RESP_OKAY, r)
        fill(p, 1);
        `CHK("frozen", drv(q, 1'b1, 1'b1), drive_outputs)
        // two falls closer than the legal period, shifting still off
        ctrl.send_bit(1'b0, -1);
        ctrl.send_bit(1'b0, -1);
        axi_rd(OFS_STATUS);
        `CHK("fast_set", 1'b1, d[STAT_FAST_BIT])
        axi_wr(OFS_CTRL, 32'h0000_0003);
        axi_rd(OFS_STATUS);
        `CHK("stat_casc", q[N-1], d[STAT_CASCADE_BIT])
        `CHK("fast_clr", 1'b0, d[STAT_FAST_BIT])
        `CHK("count", 16'(5 * N), d[STAT_COUNT_LSB +: 16])
        `CHK("stat_role", 1'b1, d[STAT_ROLE_BIT])
        axi_rd(OFS_CTRL);
        `CHK("ctrl", 32'h0000_0001, d)
        axi_rd(OFS_LATCH2);
        `CHK("latch2", {16'h0000, q[N-1:64]}, d)
        axi_rd(32'h0000_0040);
        `CHK("rresp_bad", RESP_DECERR, r)
        axi_wr(32'h0000_0044, 32'h0000_0001);
        `CHK("bresp_bad", RESP_DECERR, r)
        conclude();
    end

endmodule // testbench

`default_nettype wire

//--- verilog/lcd_row_column_driver.sv
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// RQ1: each shift clock falling edge shifts the register, serial input enters; here only while control bit CTRL_SHIFT_EN_BIT is set.
// RQ2: serial input high means selected dot, low means non-selected.
// RQ3: cascade output always shows the last register stage.
// RQ4: system chains cascade output into next driver's serial input.
// RQ5: latch strobe high makes the latch follow the shift register.
// RQ6: latch strobe low holds the latch, ignoring further shifts.
// RQ7: controller toggles alternation input; device only uses it for levels. Here it is also read back in status bit STAT_ALT_BIT.
// RQ8: role select high is common role, low is segment role.
// RQ9: common role level table from latched bit and alternation.
// RQ10: segment role level table from latched bit and alternation.
// RQ11: board ties strobe and role high when used as common driver.
// RQ12: output n follows latch bit n one for one.
// RQ13: controller keeps shift clock at or below 3.3 MHz.
// RQ14: levels coded 00 high, 01 bias upper, 10 bias lower, 11 low.
// RQ15: bits move from position 1 toward the last position.
module lcd_row_column_driver
    import lcd_driver_pkg::*;
#(
    parameter int NUM_DOTS = lcd_driver_pkg::NUM_DOTS_DEF
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // controller link
    input  wire logic                  serial_display_in,
    input  wire logic                  shift_clock_pin,
    input  wire logic                  load_strobe,
    input  wire logic                  frame_alternation,
    input  wire logic                  role_select,
    output logic                       cascade_out,
    output logic      [2*NUM_DOTS-1:0] drive_outputs,
    // axi4-lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // axi4-lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic      [1:0]            s_axi_bresp,
    // axi4-lite read
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [31:0]           s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic      [31:0]           s_axi_rdata,
    output logic      [1:0]            s_axi_rresp
);
    import lcd_driver_pkg::*;

    // readout packs the latch into three words
    if (NUM_DOTS < 2 || NUM_DOTS > LATCH_BITS)
    begin : g_bad_size
        $error("NUM_DOTS must lie between 2 and 96");
    end

    logic [NUM_DOTS-1:0]   shift_q;
    logic [NUM_DOTS-1:0]   latch_q;
    logic [2*NUM_DOTS-1:0] codes;
    logic [LATCH_BITS-1:0] latch_ext;
    logic                  clk_pin_q;
    logic                  shift_en_q;
    logic                  fast_q;
    logic [3:0]            gap_q;
    logic [15:0]           count_q;
    logic                  fall;
    logic                  do_shift;
    logic                  aw_got_q;
    logic                  w_got_q;
    logic [31:0]           awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  wr_fire;
    logic                  clr_fast;
    logic [31:0]           status;

    // shift clock is synchronous, so an edge is simply a change seen here
    assign fall     = clk_pin_q && !shift_clock_pin;
    assign do_shift = fall && shift_en_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            clk_pin_q <= 1'b0;
        else
            clk_pin_q <= shift_clock_pin;
    end

    // shift register, position 1 is bit 0 [RQ15]
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            shift_q <= '0;
        else if (do_shift)
            shift_q <= {shift_q[NUM_DOTS-2:0], serial_display_in}; // [RQ1]
    end

    // last stage feeds the next device in the chain [RQ3]
    assign cascade_out = shift_q[NUM_DOTS-1];

    // level-sensitive latch modelled per clock [RQ5] [RQ6]
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            latch_q <= '0;
        else if (load_strobe)
            latch_q <= shift_q;
    end

    level_encoder #(
        .N                 (NUM_DOTS)
    ) u_enc (
        .dot_bits          (latch_q),
        .frame_alternation (frame_alternation),
        .role_select       (role_select),
        .level_codes       (codes)
    );

    // outputs registered to keep level glitches off the pins [RQ12]
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            drive_outputs <= '0;
        else
            drive_outputs <= codes;
    end

    // shift counter and over-speed watch; set beats clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gap_q   <= '0;
            fast_q  <= 1'b0;
            count_q <= '0;
        end
        else
        begin
            if (fall)
                gap_q <= 4'h1;
            else if (gap_q != 4'hf)
                gap_q <= gap_q + 4'h1;
            if (do_shift)
                count_q <= count_q + 16'h0001;
            if (fall && gap_q < GAP_MIN && count_q != 16'h0000)
                fast_q <= 1'b1;
            else if (clr_fast)
                fast_q <= 1'b0;
        end
    end

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign wr_fire       = aw_got_q && w_got_q;
    assign clr_fast      = wr_fire && awaddr_q == OFS_CTRL && wstrb_q[0]
                           && wdata_q[CTRL_CLR_FAST_BIT];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            shift_en_q   <= CTRL_SHIFT_EN_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (awaddr_q == OFS_CTRL && wstrb_q[0])
                    shift_en_q <= wdata_q[CTRL_SHIFT_EN_BIT];
                else if (awaddr_q != OFS_STATUS && awaddr_q != OFS_LATCH0
                         && awaddr_q != OFS_LATCH1
                         && awaddr_q != OFS_LATCH2
                         && awaddr_q != OFS_CTRL)
                    s_axi_bresp <= RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read side views
    always_comb
    begin
        latch_ext = '0;
        latch_ext[NUM_DOTS-1:0] = latch_q;
        status = '0;
        status[STAT_CASCADE_BIT] = cascade_out;
        status[STAT_LOAD_BIT]    = load_strobe;
        status[STAT_ROLE_BIT]    = role_select;
        status[STAT_ALT_BIT]     = frame_alternation;
        status[STAT_FAST_BIT]    = fast_q;
        status[STAT_COUNT_LSB +: 16] = count_q;
    end

    // read channel, one outstanding read
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL:   s_axi_rdata <= {31'h0000_0000, shift_en_q};
                OFS_STATUS: s_axi_rdata <= status;
                OFS_LATCH0: s_axi_rdata <= latch_ext[31:0];
                OFS_LATCH1: s_axi_rdata <= latch_ext[63:32];
                OFS_LATCH2: s_axi_rdata <= latch_ext[95:64];
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_shift_on_fall: assert property (do_shift |=> // [RQ1]
        shift_q[NUM_DOTS-1:1] == $past(shift_q[NUM_DOTS-2:0]))
        else $error("shift register did not move on falling edge");
    a_input_polarity: assert property (do_shift |=> // [RQ2]
        shift_q[0] == $past(serial_display_in))
        else $error("serial bit not captured with its own polarity");
    a_cascade_last: assert property (do_shift |=> // [RQ3] [RQ15]
        cascade_out == $past(shift_q[NUM_DOTS-2]))
        else $error("cascade output is not the last stage");
    a_shift_idle: assert property (!fall |=> $stable(shift_q)) // [RQ1]
        else $error("shift register moved without a falling edge");
    a_latch_follow: assert property (load_strobe |=> // [RQ5]
        latch_q == $past(shift_q))
        else $error("transparent latch did not follow shift register");
    a_latch_hold: assert property (!load_strobe |=> // [RQ6]
        $stable(latch_q))
        else $error("latch changed while strobe low");
    a_common_select: assert property // [RQ8] [RQ9]
        (latch_q[0] && role_select && frame_alternation |=>
         drive_outputs[1:0] == LVL_HIGH_RAIL)
        else $error("common select level wrong");
    a_segment_select: assert property // [RQ8] [RQ10]
        (latch_q[0] && !role_select && frame_alternation |=>
         drive_outputs[1:0] == LVL_LOW_RAIL)
        else $error("segment select level wrong");
    a_nonselect_bias: assert property // [RQ12] [RQ14]
        (!latch_q[NUM_DOTS-1] && !frame_alternation |=>
         drive_outputs[2*NUM_DOTS-1 -: 2] == LVL_BIAS_UPPER)
        else $error("non-select bias level wrong on last output");

    c_shift: cover property (do_shift ##[1:20] do_shift);
    c_load_pass: cover property (do_shift ##1 load_strobe [*2]);
    c_common_drive: cover property (role_select && load_strobe
        && frame_alternation ##1 !frame_alternation);
    c_hold_shift: cover property (!load_strobe && do_shift);

endmodule // lcd_row_column_driver

`default_nettype wire

//--- verilog/level_encoder.sv
`timescale 1ns/10ps
`default_nettype none

module level_encoder
    import lcd_driver_pkg::*;
#(
    parameter int N = 80
)
(
    // latched dots
    input  wire logic [N-1:0]   dot_bits,
    // drive selection
    input  wire logic           frame_alternation,
    input  wire logic           role_select,
    // per-output level codes
    output logic      [2*N-1:0] level_codes
);

    // one selector per output
    for (genvar k = 0; k < N; k++)
    begin : g_out
        always_comb
        begin
            if (dot_bits[k]) // [RQ2]
            begin
                // high rail when alternation agrees with role [RQ9] [RQ10]
                if (frame_alternation == role_select) // [RQ8]
                    level_codes[2*k +: 2] = LVL_HIGH_RAIL;
                else
                    level_codes[2*k +: 2] = LVL_LOW_RAIL;
            end
            else if (frame_alternation)
                level_codes[2*k +: 2] = LVL_BIAS_LOWER; // [RQ14]
            else
                level_codes[2*k +: 2] = LVL_BIAS_UPPER;
        end
    end

endmodule // level_encoder

`default_nettype wire
